// ### dpw_pkg.sv
// constants and types of the dual pulse-width generator
package dpw_pkg;

  // register indices; each byte address is four times its index
  localparam logic [9:0] IDX_CTRL0 = 10'h370;
  localparam logic [9:0] IDX_PRE0  = 10'h372;
  localparam logic [9:0] IDX_WID0  = 10'h373;
  localparam logic [9:0] IDX_PRE1  = 10'h374;
  localparam logic [9:0] IDX_WID1  = 10'h375;
  localparam logic [9:0] IDX_CTRL1 = 10'h376;

  // pulse_control_0 fields
  localparam int unsigned SEL0_BIT  = 0;
  localparam int unsigned SEL1_BIT  = 1;
  localparam int unsigned CLK_LSB   = 6;
  localparam logic [7:0]  CTRL0_MASK = 8'hc3;
  // pulse_control_1 fields
  localparam int unsigned EN0_BIT   = 0;
  localparam int unsigned EN1_BIT   = 1;
  localparam int unsigned PORT0_BIT = 2;
  localparam int unsigned PORT1_BIT = 3;
  localparam logic [7:0]  CTRL1_MASK = 8'h0f;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] VAL_RST  = 8'h00;

  // last step of the 255-step period
  localparam logic [7:0] STEP_LAST = 8'hfe;

  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_CTRL0 = 3'b001,
    SEL_PRE0  = 3'b010,
    SEL_WID0  = 3'b011,
    SEL_PRE1  = 3'b100,
    SEL_WID1  = 3'b101,
    SEL_CTRL1 = 3'b110
  } dpw_reg_sel_type;

endpackage

// ### dpw_channel.sv
// one pulse-width channel: prelatches, latches, prescaler and step counter
`timescale 1ns/10ps
module dpw_channel
  import dpw_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       wr_pre,
  input  wire logic       wr_wid,
  input  wire logic [7:0] wdata,
  output logic            pulse,
  output logic [7:0]      pre_rd,
  output logic [7:0]      wid_rd
);

  typedef struct packed {
    logic [7:0] pre_pl;
    logic [7:0] pre_lat;
    logic [7:0] wid_pl;
    logic [7:0] wid_lat;
    logic [7:0] pre_cnt;
    logic [7:0] step;
    logic       out;
  } dpw_chan_type;

  dpw_chan_type st_q;
  dpw_chan_type st_d;
  logic         wrap;

  always_comb begin
    st_d = st_q;
    wrap = 1'b0;
    if (ce) begin
      if (wr_pre) begin
        st_d.pre_pl = wdata;
      end
      if (wr_wid) begin
        st_d.wid_pl = wdata;
      end
      // disabled: counters, latches and level all hold
      if (enable && tick) begin
        if (st_q.pre_cnt == st_q.pre_lat) begin
          st_d.pre_cnt = 8'h00;
          if (st_q.step == STEP_LAST) begin
            wrap         = 1'b1;
            st_d.step    = 8'h00;
            st_d.pre_lat = st_q.pre_pl;
            st_d.wid_lat = st_q.wid_pl;
          end else begin
            st_d.step = st_q.step + 8'h01;
          end
        end else begin
          st_d.pre_cnt = st_q.pre_cnt + 8'h01;
        end
      end
      if (enable) begin
        st_d.out = (st_d.step < st_d.wid_lat);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse  = st_q.out;
  // while enabled the prescale read shows the running count
  assign pre_rd = enable ? st_q.pre_cnt : st_q.pre_pl;
  assign wid_rd = st_q.wid_lat;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wrap_s;
    ce && enable && tick && st_q.pre_cnt == st_q.pre_lat &&
      st_q.step == STEP_LAST;
  endsequence

  latch_load_a: assert property (
    wrap_s |=> st_q.step == 8'h00 && st_q.pre_lat == $past(st_q.pre_pl) &&
               st_q.wid_lat == $past(st_q.wid_pl))
    else $error("latches not loaded at period start");

  hold_disabled_a: assert property (
    ce && !enable |=> $stable(st_q.out) && $stable(st_q.pre_lat) &&
                      $stable(st_q.wid_lat) && $stable(st_q.step))
    else $error("state moved while channel disabled");

  level_width_a: assert property (
    ce && enable |=> st_q.out == (st_q.step < st_q.wid_lat))
    else $error("output level does not match width");

  step_range_a: assert property (
    st_q.step <= STEP_LAST)
    else $error("step counter beyond period");

  first_period_a: assert property (
    ce && $rose(enable) && !wrap |=> $stable(st_q.pre_lat) &&
      $stable(st_q.wid_lat))
    else $error("new values used in first period");

endmodule

// ### dpw_top.sv
// dual 8-bit pulse-width generator with an axi4-lite register slave
`timescale 1ns/10ps
module dpw_top
  import dpw_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [1:0]             port_a_pulse,
  output logic [1:0]             port_a_func,
  output logic [1:0]             port_b_pulse,
  output logic [1:0]             port_b_func
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // register decode shared by write and read paths
  function automatic dpw_reg_sel_type reg_decode(
    input logic [ADDR_W-1:0] addr
  );
    dpw_reg_sel_type sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'b00) begin
      case (10'(addr[ADDR_W-1:2]))
        IDX_CTRL0: sel = SEL_CTRL0;
        IDX_PRE0:  sel = SEL_PRE0;
        IDX_WID0:  sel = SEL_WID0;
        IDX_PRE1:  sel = SEL_PRE1;
        IDX_WID1:  sel = SEL_WID1;
        IDX_CTRL1: sel = SEL_CTRL1;
        default:   sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // low divider bits that must all be set for a count-source tick
  function automatic logic [3:0] div_mask(input logic [1:0] clk_sel);
    logic [3:0] m;
    case (clk_sel)
      2'b00:   m = 4'h1;
      2'b01:   m = 4'h3;
      2'b10:   m = 4'h7;
      default: m = 4'hf;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0]        wbyte;
    logic              wlane;
    logic [7:0]        ctrl0;
    logic [7:0]        ctrl1;
    logic [3:0]        div;
    logic              tick;
    logic [1:0]        port_a_pulse;
    logic [1:0]        port_a_func;
    logic [1:0]        port_b_pulse;
    logic [1:0]        port_b_func;
  } dpw_top_type;

  dpw_top_type     st_q;
  dpw_top_type     st_d;
  dpw_reg_sel_type wsel;
  dpw_reg_sel_type rsel;
  logic            commit;
  logic [1:0]      wr_pre;
  logic [1:0]      wr_wid;
  logic [1:0]      ch_en;
  logic [1:0]      ch_pulse;
  logic [7:0]      pre_rd [2];
  logic [7:0]      wid_rd [2];
  logic [1:0]      clk_sel;
  logic [1:0]      pin_sel;
  logic [1:0]      port_sw;

  assign clk_sel = st_q.ctrl0[CLK_LSB+1:CLK_LSB];
  assign pin_sel = {st_q.ctrl0[SEL1_BIT], st_q.ctrl0[SEL0_BIT]};
  assign port_sw = {st_q.ctrl1[PORT1_BIT], st_q.ctrl1[PORT0_BIT]};
  assign ch_en   = {st_q.ctrl1[EN1_BIT], st_q.ctrl1[EN0_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d   = st_q;
    commit = 1'b0;
    wsel   = SEL_NONE;
    rsel   = SEL_NONE;
    wr_pre = 2'b00;
    wr_wid = 2'b00;
    if (ce) begin
      // write address and data are taken in either order
      if (st_q.awready && awvalid) begin
        st_d.aw_full = 1'b1;
        st_d.awaddr  = awaddr;
      end
      if (st_q.wready && wvalid) begin
        st_d.w_full = 1'b1;
        st_d.wbyte  = wdata[7:0];
        st_d.wlane  = wstrb[0];
      end
      if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
        commit       = 1'b1;
        wsel         = reg_decode(st_q.awaddr);
        st_d.aw_full = 1'b0;
        st_d.w_full  = 1'b0;
        st_d.bvalid  = 1'b1;
        st_d.bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        // only byte lane 0 carries register data
        if (st_q.wlane) begin
          case (wsel)
            SEL_CTRL0: st_d.ctrl0 = st_q.wbyte & CTRL0_MASK;
            SEL_CTRL1: st_d.ctrl1 = st_q.wbyte & CTRL1_MASK;
            SEL_PRE0:  wr_pre[0] = 1'b1;
            SEL_PRE1:  wr_pre[1] = 1'b1;
            SEL_WID0:  wr_wid[0] = 1'b1;
            SEL_WID1:  wr_wid[1] = 1'b1;
            default:   ;
          endcase
        end
      end
      if (st_q.bvalid && bready) begin
        st_d.bvalid = 1'b0;
      end
      st_d.awready = !st_d.aw_full && !st_d.bvalid;
      st_d.wready  = !st_d.w_full && !st_d.bvalid;

      // one read at a time; data captured when the address is taken
      if (st_q.arready && arvalid) begin
        rsel         = reg_decode(araddr);
        st_d.arready = 1'b0;
        st_d.rvalid  = 1'b1;
        st_d.rresp   = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        case (rsel)
          SEL_CTRL0: st_d.rdata = {24'h000000, st_q.ctrl0};
          SEL_CTRL1: st_d.rdata = {24'h000000, st_q.ctrl1};
          SEL_PRE0:  st_d.rdata = {24'h000000, pre_rd[0]};
          SEL_PRE1:  st_d.rdata = {24'h000000, pre_rd[1]};
          SEL_WID0:  st_d.rdata = {24'h000000, wid_rd[0]};
          SEL_WID1:  st_d.rdata = {24'h000000, wid_rd[1]};
          default:   st_d.rdata = 32'h00000000;
        endcase
      end else if (st_q.rvalid && rready) begin
        st_d.rvalid  = 1'b0;
        st_d.arready = 1'b1;
      end else if (!st_q.rvalid) begin
        st_d.arready = 1'b1;
      end

      // shared count source from the system clock
      st_d.div  = st_q.div + 4'h1;
      st_d.tick = ((st_q.div & div_mask(clk_sel)) ==
                   div_mask(clk_sel));

      // pin routing; a routed pin keeps the frozen level when disabled
      for (int i = 0; i < 2; i++) begin
        st_d.port_a_func[i]  = port_sw[i] && !pin_sel[i];
        st_d.port_b_func[i]  = port_sw[i] && pin_sel[i];
        st_d.port_a_pulse[i] = st_d.port_a_func[i] && ch_pulse[i];
        st_d.port_b_pulse[i] = st_d.port_b_func[i] && ch_pulse[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= '0;
      st_q.ctrl0 <= CTRL_RST;
      st_q.ctrl1 <= CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels

  for (genvar g = 0; g < 2; g++) begin : gen_ch
    dpw_channel u_ch (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .tick    (st_q.tick),
      .enable  (ch_en[g]),
      .wr_pre  (wr_pre[g]),
      .wr_wid  (wr_wid[g]),
      .wdata   (st_q.wbyte),
      .pulse   (ch_pulse[g]),
      .pre_rd  (pre_rd[g]),
      .wid_rd  (wid_rd[g])
    );
  end

  assign awready      = st_q.awready;
  assign wready       = st_q.wready;
  assign arready      = st_q.arready;
  assign bvalid       = st_q.bvalid;
  assign bresp        = st_q.bresp;
  assign rvalid       = st_q.rvalid;
  assign rresp        = st_q.rresp;
  assign rdata        = st_q.rdata;
  assign port_a_pulse = st_q.port_a_pulse;
  assign port_a_func  = st_q.port_a_func;
  assign port_b_pulse = st_q.port_b_pulse;
  assign port_b_func  = st_q.port_b_func;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence write_commit_s;
    commit;
  endsequence

  write_resp_a: assert property (
    write_commit_s |=> st_q.bvalid && !st_q.aw_full && !st_q.w_full)
    else $error("write response missing after commit");

  clk_field_a: assert property (
    write_commit_s ##0 (reg_decode(st_q.awaddr) == SEL_CTRL0 &&
      st_q.wlane) |=> clk_sel == $past(st_q.wbyte[CLK_LSB+1:CLK_LSB]))
    else $error("count source field not written");

  tick_rate_a: assert property (
    ce && (st_q.div & div_mask(clk_sel)) != div_mask(clk_sel) |=> !st_q.tick)
    else $error("tick outside divider boundary");

  route_a_a: assert property (
    ce && port_sw[0] && !pin_sel[0] |=>
      port_a_pulse[0] == $past(ch_pulse[0]) && !port_b_func[0])
    else $error("channel 0 not routed to port a");

  route_b_a: assert property (
    ce && port_sw[1] && pin_sel[1] |=>
      port_b_pulse[1] == $past(ch_pulse[1]) && !port_a_func[1])
    else $error("channel 1 not routed to port b");

  read_pre_a: assert property (
    ce && st_q.arready && arvalid && reg_decode(araddr) == SEL_PRE0 &&
      !ch_en[0] |=> st_q.rvalid && st_q.rdata[7:0] == $past(pre_rd[0]))
    else $error("prescale read not from prelatch");

  read_wid_a: assert property (
    ce && st_q.arready && arvalid && reg_decode(araddr) == SEL_WID1 |=>
      st_q.rdata[7:0] == $past(wid_rd[1]) && st_q.rdata[31:8] == 24'h0)
    else $error("width read not from latch");

  reset_low_a: assert property (
    $rose(aresetn) |-> port_a_pulse == 2'b00 && port_b_pulse == 2'b00)
    else $error("pin outputs not low after reset");

  freeze_ce_a: assert property (
    !ce |=> $stable(st_q))
    else $error("state changed with clock enable low");

endmodule

// ### dpw_top_tb.sv
// self-checking bench of the dual pulse-width generator
`timescale 1ns/10ps
module dpw_top_tb
  import dpw_pkg::*;
;
  `define check_eq(nm, e, s) \
    begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
      $display("unexpected %s exp %0h got %0h", nm, (e), (s)); end end

  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic [11:0] awaddr;
  logic [2:0]  awprot;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic [2:0]  arprot;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [1:0]  port_a_pulse;
  logic [1:0]  port_a_func;
  logic [1:0]  port_b_pulse;
  logic [1:0]  port_b_func;
  int          miscompares;
  int          cmp_count;
  int          cycles;

  dpw_top DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .port_a_pulse(port_a_pulse),
    .port_a_func(port_a_func), .port_b_pulse(port_b_pulse),
    .port_b_func(port_b_func)
  );

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      close_out;
    end
  end

  function automatic logic [11:0] ad(logic [9:0] i);
    return {i, 2'b00};
  endfunction

  function automatic logic pin(bit b, int c);
    return b ? port_b_pulse[c] : port_a_pulse[c];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic s, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= {3'b000, s};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic wok(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 1'b1, r);
    `check_eq("write resp", RESP_OKAY, r)
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // waits for the next rising edge of a pin; n cycles, h of them high
  task automatic rise(input bit b, input int c, output int n, output int h);
    logic p;
    n = 0;
    h = 0;
    forever begin
      p = pin(b, c);
      @(posedge aclk);
      n++;
      if (pin(b, c) === 1'b1) h++;
      if (p === 1'b0 && pin(b, c) === 1'b1) break;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  idx [6] = '{IDX_CTRL0, IDX_PRE0, IDX_WID0,
                             IDX_PRE1, IDX_WID1, IDX_CTRL1};
    `check_eq("pins", 4'h0, {port_a_pulse, port_b_pulse})
    foreach (idx[k]) begin
      rd(ad(idx[k]), d, r);
      `check_eq("reset value", {24'h0, VAL_RST}, d)
    end
    rd(12'hdc4, d, r);
    `check_eq("unmapped read", RESP_SLVERR, r)
    $display("test reset done");
  endtask

  task automatic t_access;
    logic [31:0] d;
    logic [1:0]  r;
    wok(ad(IDX_PRE0), 8'h12);
    rd(ad(IDX_PRE0), d, r);
    `check_eq("prescale prelatch", 32'h12, d)
    wok(ad(IDX_WID0), 8'h34);
    rd(ad(IDX_WID0), d, r);
    `check_eq("width latch", 32'h00, d)
    wr(ad(IDX_PRE0), 8'hff, 1'b0, r);
    rd(ad(IDX_PRE0), d, r);
    `check_eq("no strobe", 32'h12, d)
    wr(12'hdc4, 8'h55, 1'b1, r);
    `check_eq("unmapped write", RESP_SLVERR, r)
    wok(ad(IDX_CTRL0), 8'hff); // channels disabled here
    rd(ad(IDX_CTRL0), d, r);
    `check_eq("ctrl0 fields", {24'h0, CTRL0_MASK}, d)
    wok(ad(IDX_CTRL0), 8'h00);
    wok(ad(IDX_CTRL1), 8'hf0);
    rd(ad(IDX_CTRL1), d, r);
    `check_eq("ctrl1 fields", 32'h00, d)
    $display("test access done");
  endtask

  task automatic t_first;
    int n;
    int h;
    wok(ad(IDX_PRE0), 8'h00);
    wok(ad(IDX_WID0), 8'h40);
    wok(ad(IDX_CTRL1), 8'h05); // pin direction is set outside
    @(posedge aclk); // pin flops are launched at the response edge
    `check_eq("func a", 2'b01, port_a_func)
    `check_eq("func b", 2'b00, port_b_func)
    h = 0;
    repeat (490) begin
      @(posedge aclk);
      if (port_a_pulse[0] === 1'b1) h++;
    end
    `check_eq("first period high", 0, h)
    rise(1'b0, 0, n, h);
    `check_eq("wrap soon", 1'b1, n < 100)
    rise(1'b0, 0, n, h);
    `check_eq("period", 510, n)
    `check_eq("high time", 128, h)
    $display("test first period done");
  endtask

  task automatic t_prescale;
    int n;
    int h;
    wok(ad(IDX_PRE0), 8'h01); // written while running
    rise(1'b0, 0, n, h);
    rise(1'b0, 0, n, h);
    `check_eq("period", 1020, n)
    `check_eq("high time", 256, h)
    $display("test prescale done");
  endtask

  task automatic t_freeze;
    int          n;
    int          h;
    logic [31:0] d;
    logic [1:0]  r;
    rise(1'b0, 0, n, h);
    wok(ad(IDX_CTRL1), 8'h04);
    h = 0;
    repeat (300) begin
      @(posedge aclk);
      if (port_a_pulse[0] === 1'b1) h++;
    end
    `check_eq("frozen level", 300, h)
    rd(ad(IDX_WID0), d, r);
    `check_eq("width kept", 32'h40, d)
    rd(ad(IDX_PRE0), d, r);
    `check_eq("prescale kept", 32'h01, d)
    $display("test freeze done");
  endtask

  task automatic t_sources;
    int n;
    int h;
    for (int s = 0; s < 4; s++) begin
      wok(ad(IDX_CTRL0), {s[1:0], 6'h02}); // disabled now
      wok(ad(IDX_PRE1), 8'h00);
      wok(ad(IDX_WID1), 8'h0a);
      wok(ad(IDX_CTRL1), 8'h0e); // pin direction set outside
      @(posedge aclk); // pin flops are launched at the response edge
      `check_eq("func b", 2'b10, port_b_func)
      `check_eq("func a", 2'b01, port_a_func)
      rise(1'b1, 1, n, h);
      rise(1'b1, 1, n, h);
      rise(1'b1, 1, n, h);
      `check_eq("period", 255 * (2 << s), n)
      `check_eq("high time", 10 * (2 << s), h)
      wok(ad(IDX_CTRL1), 8'h04); // stop before the source changes
    end
    `check_eq("other channel", 1'b1, port_a_pulse[0])
    $display("test sources done");
  endtask

  // clock enable low must freeze a running channel mid high phase
  task automatic t_stall;
    int         moved;
    logic [3:0] p;
    wok(ad(IDX_CTRL1), 8'h0e);
    ce <= 1'b0;
    @(posedge aclk);
    p     = {port_a_pulse, port_b_pulse};
    moved = 0;
    repeat (200) begin
      @(posedge aclk);
      if ({port_a_pulse, port_b_pulse} !== p) moved++;
    end
    ce <= 1'b1;
    `check_eq("stalled pins", 0, moved)
    `check_eq("stalled level", 1'b1, p[1])
    $display("test stall done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk        = 1'b0;
    aresetn     = 1'b0;
    ce          = 1'b1;
    awaddr      = 12'h000;
    awprot      = 3'h0;
    awvalid     = 1'b0;
    wdata       = 32'h0;
    wstrb       = 4'h0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = 12'h000;
    arprot      = 3'h0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_access;
    t_first;
    t_prescale;
    t_freeze;
    t_sources;
    t_stall;
    close_out;
  end
endmodule
